// File: shared/fci_consts.vh
// Purpose: constants for the flash command-sequence host controller
// Assumes: word-wide command writes, 15-bit unlock address decode
// Notes: timing counts in core clock cycles at 250 MHz
`ifndef FCI_CONSTS_VH
`define FCI_CONSTS_VH

`define FCI_UNLOCK_ADDR1 15'h5555
`define FCI_UNLOCK_ADDR2 15'h2aaa
`define FCI_UNLOCK_DATA1 8'haa
`define FCI_UNLOCK_DATA2 8'h55
`define FCI_CMD_RESET 8'hf0
`define FCI_CMD_ID 8'h90
`define FCI_CMD_PROG 8'ha0
`define FCI_CMD_ERASE 8'h80
`define FCI_CMD_STATUS 8'h70
`define FCI_CMD_CLRSTAT 8'h50
`define FCI_CMD_PROT 8'h60
`define FCI_CMD_ABORT 8'he0
`define FCI_CMD_CHIP 8'h10
`define FCI_CMD_SECTOR 8'h30
`define FCI_CMD_PROTECT 8'h20
`define FCI_CMD_UNPROTECT 8'h40
`define FCI_SECT_LO 5
`define FCI_SECT_BOTTOM 5'h00
`define FCI_SECT_TOP 5'h1f
`define FCI_ID_MFR_ADDR 20'h00000
`define FCI_ID_DEV_ADDR 20'h00001
// operation codes on the user port
`define FCI_OP_RESET 4'h0
`define FCI_OP_ID 4'h1
`define FCI_OP_PROG 4'h2
`define FCI_OP_CHIP 4'h3
`define FCI_OP_SECTOR 4'h4
`define FCI_OP_STATUS 4'h5
`define FCI_OP_CLRSTAT 4'h6
`define FCI_OP_PROTECT 4'h7
`define FCI_OP_UNPROTECT 4'h8
`define FCI_OP_ABORT 4'h9
`define FCI_OP_READ 4'ha
`define FCI_OP_VERIFY 4'hb
// bus cycle phase lengths in ns and cycles (least times rounded up)
`define FCI_CLK_NS 4
`define FCI_SETUP_NS 40
`define FCI_PULSE_NS 60
`define FCI_READ_NS 120
`define FCI_SETUP_CYC ((`FCI_SETUP_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS)
`define FCI_PULSE_CYC ((`FCI_PULSE_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS)
`define FCI_READ_CYC ((`FCI_READ_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS)

`endif

// File: rtl/fci_bus_cycle.v
// Purpose: one flash bus cycle (write or read) on the chip-select/output-gate pins
// Assumes: pin data input already passed through two flip-flops upstream
// Notes: write latches address on chip-select fall, data on its rise
`timescale 1ns/1ns
`default_nettype none
`include "fci_consts.vh"
module fci_bus_cycle #(
    parameter SETUP_CYC = `FCI_SETUP_CYC,
    parameter PULSE_CYC = `FCI_PULSE_CYC,
    parameter READ_CYC = `FCI_READ_CYC
) (
    input wire core_clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire start_i,
    input wire wr_i,
    input wire [19:0] addr_i,
    input wire [15:0] wdata_i,
    input wire [15:0] pin_q_sync_i,
    output reg done_o,
    output reg [15:0] rdata_o,
    output reg [19:0] addr_pin_o,
    output reg [15:0] q_out_o,
    output reg q_oe_o,
    output reg cs_n_o,
    output reg og_n_o
);
    // ----------------------------------------------------------------
    // cycle sequencer
    // ----------------------------------------------------------------
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_SETUP = 4'b0010;
    localparam [3:0] ST_PULSE = 4'b0100;
    localparam [3:0] ST_HOLD = 4'b1000;
    reg [3:0] state_reg;
    reg [7:0] cnt_reg;
    reg wr_reg;

    // address and data set up before the strobe, strobe, then release
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 8'h00;
            wr_reg <= 1'b0;
            done_o <= 1'b0;
            rdata_o <= 16'h0000;
            addr_pin_o <= 20'h00000;
            q_out_o <= 16'h0000;
            q_oe_o <= 1'b0;
            cs_n_o <= 1'b1;
            og_n_o <= 1'b1;
        end else if (ce_i) begin
            done_o <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (start_i) begin
                        wr_reg <= wr_i;
                        addr_pin_o <= addr_i;
                        q_out_o <= wdata_i;
                        q_oe_o <= wr_i;
                        cnt_reg <= SETUP_CYC[7:0];
                        state_reg <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    if (cnt_reg <= 8'h01) begin
                        cs_n_o <= 1'b0; // address taken on this fall
                        og_n_o <= wr_reg; // output gate high for writes
                        cnt_reg <= wr_reg ? PULSE_CYC[7:0] : READ_CYC[7:0];
                        state_reg <= ST_PULSE;
                    end else begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end
                end
                ST_PULSE: begin
                    if (cnt_reg <= 8'h01) begin
                        // data taken by the device on this rise
                        rdata_o <= pin_q_sync_i;
                        cs_n_o <= 1'b1;
                        og_n_o <= 1'b1;
                        cnt_reg <= SETUP_CYC[7:0];
                        state_reg <= ST_HOLD;
                    end else begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end
                end
                ST_HOLD: begin
                    if (cnt_reg <= 8'h01) begin
                        q_oe_o <= 1'b0;
                        done_o <= 1'b1;
                        state_reg <= ST_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// File: rtl/fci_host.v
// Purpose: host controller issuing unlocked command sequences to a parallel flash
// Assumes: programming supply is switched outside from the vpp_en_o output
// Notes: one user operation per request; answers with a done pulse
//
// Function
// - host writes only word-wide, with program supply raised, chip-select low, gate high
// - every command opens with AAH to 5555H then 55H to 2AAAH
// - erase setup adds unlock pair and 10H chip or 30H sector write
// - protect setup adds unlock pair then 20H protect or 40H unprotect at sector
// - host writes read/reset before expecting array data again
`timescale 1ns/1ns
`default_nettype none
`include "fci_consts.vh"
module fci_host #(
    parameter SETUP_CYC = `FCI_SETUP_CYC,
    parameter PULSE_CYC = `FCI_PULSE_CYC,
    parameter READ_CYC = `FCI_READ_CYC
) (
    input wire core_clk_i,
    input wire rst_i,
    input wire clk_en_i,
    input wire req_i,
    input wire [3:0] op_i,
    input wire [19:0] addr_i,
    input wire [15:0] data_i,
    input wire byte_mode_i,
    input wire [15:0] q_i,
    output reg busy_o,
    output reg done_o,
    output reg [15:0] rdata_o,
    output reg engine_busy_o,
    output wire [19:0] addr_o,
    output wire [15:0] q_o,
    output wire q_oe_o,
    output wire cs_n_o,
    output wire og_n_o,
    output reg vpp_en_o,
    output reg byte_n_o,
    output reg id_hv_en_o
);
    // ----------------------------------------------------------------
    // pin input synchroniser
    // ----------------------------------------------------------------
    reg [15:0] q_meta_reg;
    reg [15:0] q_sync_reg;

    // two flops before any logic looks at the data pins
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            q_meta_reg <= 16'h0000;
            q_sync_reg <= 16'h0000;
        end else if (clk_en_i) begin
            q_meta_reg <= q_i;
            q_sync_reg <= q_meta_reg;
        end
    end

    // ----------------------------------------------------------------
    // sequence engine
    // ----------------------------------------------------------------
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_LOAD = 4'b0010;
    localparam [3:0] ST_WAIT = 4'b0100;
    localparam [3:0] ST_DONE = 4'b1000;
    reg [3:0] state_reg;
    reg [2:0] step_reg;
    reg [2:0] nsteps_reg;
    reg [3:0] op_reg;
    reg [19:0] addr_reg;
    reg [15:0] data_reg;
    reg cyc_start_reg;
    reg cyc_wr_reg;
    reg [19:0] cyc_addr_reg;
    reg [15:0] cyc_data_reg;
    wire cyc_done;
    wire [15:0] cyc_rdata;

    // the step-th bus cycle of the selected sequence
    reg [19:0] seq_addr;
    reg [7:0] seq_data;
    reg seq_wr;
    always @* begin
        seq_wr = 1'b1;
        seq_addr = {5'h00, `FCI_UNLOCK_ADDR1}; // upper bits zero, decode uses 0..14
        seq_data = `FCI_UNLOCK_DATA1;
        case (step_reg)
            3'd0: seq_data = `FCI_UNLOCK_DATA1;
            3'd1: begin
                seq_addr = {5'h00, `FCI_UNLOCK_ADDR2};
                seq_data = `FCI_UNLOCK_DATA2;
            end
            3'd2: begin
                case (op_reg) // command byte on the low lane only
                    `FCI_OP_RESET: seq_data = `FCI_CMD_RESET;
                    `FCI_OP_ID: seq_data = `FCI_CMD_ID;
                    `FCI_OP_VERIFY: seq_data = `FCI_CMD_ID;
                    `FCI_OP_PROG: seq_data = `FCI_CMD_PROG;
                    `FCI_OP_CHIP: seq_data = `FCI_CMD_ERASE;
                    `FCI_OP_SECTOR: seq_data = `FCI_CMD_ERASE;
                    `FCI_OP_STATUS: seq_data = `FCI_CMD_STATUS;
                    `FCI_OP_CLRSTAT: seq_data = `FCI_CMD_CLRSTAT;
                    `FCI_OP_PROTECT: seq_data = `FCI_CMD_PROT;
                    `FCI_OP_UNPROTECT: seq_data = `FCI_CMD_PROT;
                    default: seq_data = `FCI_CMD_ABORT;
                endcase
            end
            3'd3: begin
                seq_data = `FCI_UNLOCK_DATA1; // second unlock pair
                if (op_reg == `FCI_OP_PROG) begin
                    seq_addr = addr_reg; // program location and value
                end
            end
            3'd4: begin
                seq_addr = {5'h00, `FCI_UNLOCK_ADDR2};
                seq_data = `FCI_UNLOCK_DATA2;
            end
            default: begin
                // sector picked by bits 15..19 only
                if (op_reg != `FCI_OP_CHIP) begin
                    seq_addr = {addr_reg[19:15], 15'h0000};
                end
                case (op_reg)
                    `FCI_OP_CHIP: seq_data = `FCI_CMD_CHIP;
                    `FCI_OP_SECTOR: seq_data = `FCI_CMD_SECTOR;
                    `FCI_OP_PROTECT: seq_data = `FCI_CMD_PROTECT;
                    default: seq_data = `FCI_CMD_UNPROTECT;
                endcase
            end
        endcase
        // read-phase of a read-type sequence, or a plain read
        if (step_reg == 3'd3 && (op_reg == `FCI_OP_ID || op_reg == `FCI_OP_VERIFY ||
                op_reg == `FCI_OP_STATUS || op_reg == `FCI_OP_RESET || op_reg == `FCI_OP_READ)) begin
            seq_wr = 1'b0;
            if (op_reg == `FCI_OP_VERIFY) begin
                seq_addr = {addr_reg[19:15], 13'h0000, 2'b10}; // A1 high, A0 low
            end else if (op_reg == `FCI_OP_ID) begin
                seq_addr = addr_reg[0] ? `FCI_ID_DEV_ADDR : `FCI_ID_MFR_ADDR;
            end else begin
                seq_addr = addr_reg;
            end
        end
    end

    // main sequencer, one bus cycle at a time
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
            step_reg <= 3'd0;
            nsteps_reg <= 3'd0;
            op_reg <= `FCI_OP_RESET;
            addr_reg <= 20'h00000;
            data_reg <= 16'h0000;
            cyc_start_reg <= 1'b0;
            cyc_wr_reg <= 1'b0;
            cyc_addr_reg <= 20'h00000;
            cyc_data_reg <= 16'h0000;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            rdata_o <= 16'h0000;
            engine_busy_o <= 1'b0;
            vpp_en_o <= 1'b0;
            byte_n_o <= 1'b1;
            id_hv_en_o <= 1'b0; // identifier read goes by command, pin stays low
        end else if (clk_en_i) begin
            cyc_start_reg <= 1'b0;
            done_o <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (req_i) begin
                        op_reg <= op_i;
                        addr_reg <= addr_i;
                        data_reg <= data_i;
                        busy_o <= 1'b1;
                        step_reg <= 3'd0;
                        // while the engine runs only status reads may go out
                        if (engine_busy_o && op_i != `FCI_OP_STATUS && op_i != `FCI_OP_READ) begin
                            state_reg <= ST_DONE;
                        end else begin
                            case (op_i) // counts of full sequences
                                `FCI_OP_CLRSTAT: nsteps_reg <= 3'd3;
                                `FCI_OP_ABORT: nsteps_reg <= 3'd3;
                                `FCI_OP_CHIP: nsteps_reg <= 3'd6;
                                `FCI_OP_SECTOR: nsteps_reg <= 3'd6;
                                `FCI_OP_PROTECT: nsteps_reg <= 3'd6;
                                `FCI_OP_UNPROTECT: nsteps_reg <= 3'd6;
                                // unknown codes send the three abort writes only
                                default: nsteps_reg <= (op_i > `FCI_OP_VERIFY) ? 3'd3 : 3'd4;
                            endcase
                            if (op_i == `FCI_OP_READ || (engine_busy_o && op_i == `FCI_OP_STATUS)) begin
                                step_reg <= 3'd3; // plain read, no command writes
                            end
                            // word mode for writes, raise program supply
                            byte_n_o <= (op_i == `FCI_OP_READ) ? ~byte_mode_i : 1'b1;
                            vpp_en_o <= (op_i != `FCI_OP_READ);
                            state_reg <= ST_LOAD;
                        end
                    end
                end
                ST_LOAD: begin
                    cyc_start_reg <= 1'b1;
                    cyc_wr_reg <= seq_wr;
                    cyc_addr_reg <= seq_addr;
                    // program value on full width, commands on low lane
                    cyc_data_reg <= (step_reg == 3'd3 && op_reg == `FCI_OP_PROG) ? data_reg : {8'h00, seq_data};
                    state_reg <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (cyc_done) begin
                        if (!cyc_wr_reg) begin
                            // upper byte meaningless in byte mode
                            rdata_o <= byte_n_o ? cyc_rdata : {8'h00, cyc_rdata[7:0]};
                        end
                        if (step_reg + 3'd1 >= nsteps_reg) begin
                            state_reg <= ST_DONE;
                        end else begin
                            step_reg <= step_reg + 3'd1;
                            state_reg <= ST_LOAD;
                        end
                    end
                end
                default: begin
                    // program and erase hand off to the write engine
                    if (op_reg == `FCI_OP_PROG || op_reg == `FCI_OP_CHIP || op_reg == `FCI_OP_SECTOR) begin
                        engine_busy_o <= 1'b1;
                    end else if (engine_busy_o && cyc_rdata[7] &&
                            (op_reg == `FCI_OP_STATUS || op_reg == `FCI_OP_READ)) begin
                        // only a fresh status read ends it; a refused op has no read
                        engine_busy_o <= 1'b0;
                    end
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                    vpp_en_o <= 1'b0;
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // bus cycle engine
    // ----------------------------------------------------------------
    // device takes address at chip-select fall, data at rise
    fci_bus_cycle #(
        .SETUP_CYC(SETUP_CYC),
        .PULSE_CYC(PULSE_CYC),
        .READ_CYC(READ_CYC)
    ) u_cycle (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .ce_i(clk_en_i),
        .start_i(cyc_start_reg),
        .wr_i(cyc_wr_reg),
        .addr_i(cyc_addr_reg),
        .wdata_i(cyc_data_reg),
        .pin_q_sync_i(q_sync_reg),
        .done_o(cyc_done),
        .rdata_o(cyc_rdata),
        .addr_pin_o(addr_o),
        .q_out_o(q_o),
        .q_oe_o(q_oe_o),
        .cs_n_o(cs_n_o),
        .og_n_o(og_n_o)
    );
endmodule
`default_nettype wire

// File: testbench/fci_host_sva.sv
// Purpose: pin-level checks of the flash host controller
// Assumes: sees only the top module ports
// Notes: bound to every fci_host instance
`timescale 1ns/1ns
`default_nettype none
module fci_host_sva (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic engine_busy_o,
    input wire logic [19:0] addr_o,
    input wire logic [15:0] q_o,
    input wire logic q_oe_o,
    input wire logic cs_n_o,
    input wire logic og_n_o,
    input wire logic vpp_en_o,
    input wire logic byte_n_o
);
    // ----------------------------------------
    // pin protocol
    // ----------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    chk_write_gate: assert property (!cs_n_o && q_oe_o |-> og_n_o && vpp_en_o)
        else $error("write pulse without gate high or supply");
    chk_write_word: assert property (!cs_n_o && q_oe_o |-> byte_n_o)
        else $error("write pulse in byte width");
    chk_addr_hold: assert property (!cs_n_o && $past(!cs_n_o) |-> $stable(addr_o))
        else $error("address moved while chip select low");
    chk_data_hold: assert property (!cs_n_o && q_oe_o |=> q_oe_o && $stable(q_o))
        else $error("write data moved before chip select rise");
    chk_no_fight: assert property (!og_n_o |-> !q_oe_o)
        else $error("host drives data during a read");
    chk_read_select: assert property (!og_n_o |-> !cs_n_o)
        else $error("output gate low without chip select");
    chk_done_pulse: assert property (done_o && clk_en_i |=> !done_o)
        else $error("done longer than one cycle");
    chk_idle_quiet: assert property (!busy_o && !done_o |-> cs_n_o && og_n_o && !q_oe_o)
        else $error("bus activity outside an operation");
    cov_write: cover property (!cs_n_o && q_oe_o);
    cov_read: cover property (!og_n_o);
    cov_engine: cover property ($fell(engine_busy_o));
endmodule
bind fci_host fci_host_sva chk_u (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i), .busy_o(busy_o),
    .done_o(done_o), .engine_busy_o(engine_busy_o), .addr_o(addr_o), .q_o(q_o),
    .q_oe_o(q_oe_o), .cs_n_o(cs_n_o), .og_n_o(og_n_o), .vpp_en_o(vpp_en_o),
    .byte_n_o(byte_n_o)
);
`default_nettype wire

// File: testbench/fci_flash_model.sv
// Purpose: behavioural flash device facing the host controller
// Assumes: edge-driven on chip-select and output-gate pins
// Notes: engine stays busy for two status reads after program or erase
`timescale 1ns/1ns
`default_nettype none
module fci_flash_model #(
    parameter [7:0] MFR_CODE = 8'h5a, // arbitrary value
    parameter [7:0] DEV_CODE = 8'h3c // arbitrary value
) (
    input wire logic [19:0] addr_i,
    input wire logic [15:0] q_host_i,
    input wire logic q_oe_i,
    input wire logic cs_n_i,
    input wire logic og_n_i,
    input wire logic vpp_i,
    input wire logic byte_n_i,
    input wire logic hv_i,
    output logic [15:0] q_o,
    output logic [7:0] op_cnt_o = 8'h00,
    output logic [2:0] kind_o = 3'h0,
    output logic [4:0] sect_o = 5'h00
);
    // ----------------------------------------
    // command decoder
    // ----------------------------------------
    logic [19:0] a_lat = 20'h00000;
    logic [19:0] pa = 20'hfffff;
    logic [15:0] pd = 16'h0000;
    logic [15:0] last = 16'h0000;
    logic [15:0] rd;
    logic [7:0] d;
    logic [2:0] st = 3'h0;
    logic [1:0] mode = 2'h0; // 0 array, 1 identifier, 2 status
    logic [1:0] busy_left = 2'h0;
    logic [1:0] prot = 2'h0;
    logic sub_prot = 1'b0;
    logic ok;
    task automatic rec(input [2:0] k, input logic eng);
        op_cnt_o = op_cnt_o + 8'h01;
        kind_o = k;
        sect_o = a_lat[19:15];
        if (eng) begin
            busy_left = 2'h2;
            mode = 2'h2;
        end
    endtask
    // address on chip-select fall
    always @(negedge cs_n_i) a_lat = addr_i;
    // data and command on chip-select rise
    always @(posedge cs_n_i) begin
        d = q_host_i[7:0];
        last = q_host_i;
        ok = st[0] ? (a_lat[14:0] == 15'h2aaa && d == 8'h55) : (a_lat[14:0] == 15'h5555 && d == 8'haa);
        if (og_n_i && vpp_i && byte_n_i && busy_left == 2'h0) begin
            case (st)
                3'h0, 3'h1, 3'h4, 3'h5: st = ok ? st + 3'h1 : 3'h0;
                3'h2: begin
                    st = 3'h0;
                    if (a_lat[14:0] == 15'h5555) begin
                        case (d)
                            8'hf0: mode = 2'h0;
                            8'h90: mode = 2'h1;
                            8'h70: mode = 2'h2;
                            8'ha0: st = 3'h3;
                            8'h80, 8'h60: st = 3'h4;
                            8'h50: rec(3'h6, 1'b0);
                            8'he0: rec(3'h7, 1'b0);
                            default: st = 3'h0;
                        endcase
                        sub_prot = (d == 8'h60);
                    end
                end
                3'h3: begin
                    st = 3'h0;
                    pa = a_lat;
                    pd = q_host_i;
                    rec(3'h1, 1'b1);
                end
                default: begin
                    st = 3'h0;
                    if (!sub_prot && d == 8'h10 && a_lat[14:0] == 15'h5555) rec(3'h2, 1'b1);
                    if (!sub_prot && d == 8'h30) rec(3'h3, 1'b1);
                    if (sub_prot && (a_lat[19:15] == 5'h00 || a_lat[19:15] == 5'h1f) && (d == 8'h20 || d == 8'h40)) begin
                        prot[a_lat[15]] = ~d[6];
                        rec(d[6] ? 3'h5 : 3'h4, 1'b0);
                    end
                end
            endcase
        end
    end
    // status reads count down the engine
    always @(posedge og_n_i) begin
        last = q_o;
        if (mode == 2'h2 && busy_left != 2'h0) busy_left = busy_left - 2'h1;
    end
    // read path and pin level
    always @* begin
        if (hv_i || mode == 2'h1) begin
            case (addr_i[1:0])
                2'h0: rd = {8'h00, MFR_CODE};
                2'h1: rd = {8'h00, DEV_CODE};
                2'h2: rd = (addr_i[19:15] == 5'h00 && prot[0]) || (addr_i[19:15] == 5'h1f && prot[1]) ? {8'h00, MFR_CODE} : 16'h0000;
                default: rd = 16'h0000;
            endcase
        end else if (mode == 2'h2) rd = {8'h00, busy_left == 2'h0, 7'h00};
        else rd = (addr_i == pa) ? pd : addr_i[15:0] ^ 16'h5a3c;
        if (q_oe_i) q_o = q_host_i;
        else if (!cs_n_i && !og_n_i) q_o = byte_n_i ? rd : {~last[15:8], rd[7:0]};
        else q_o = ~last;
    end
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
// Purpose: self-checking bench of the flash host controller
// Assumes: device model on the pins, shortened bus phases
// Notes: random addresses and clock-enable gaps from a fixed seed
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    localparam [7:0] MFR = 8'h5a; // arbitrary value
    localparam [7:0] DEV = 8'h3c; // arbitrary value
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic clk_en_i = 1'b1;
    logic req_i = 1'b0;
    logic byte_mode_i = 1'b0;
    logic gaps = 1'b0;
    logic [3:0] op_i = 4'h0;
    logic [19:0] addr_i = 20'h00000;
    logic [15:0] data_i = 16'h0000;
    wire [15:0] q_i, q_o, rdata_o;
    wire [19:0] addr_o;
    wire busy_o, done_o, engine_busy_o, q_oe_o, cs_n_o, og_n_o, vpp_en_o, byte_n_o, id_hv_en_o;
    wire [7:0] op_cnt;
    wire [2:0] kind;
    wire [4:0] sect;
    integer seed = 32'h11e7e811;
    int miscompares = 0;
    int tests_run = 0;
    int i, cnt, k;
    time t0;
    logic [19:0] a;
    logic [15:0] e;
    logic [3:0] ops [6] = '{4'h2, 4'h3, 4'h4, 4'h6, 4'h9, 4'hf};
    logic [2:0] kinds [6] = '{3'h1, 3'h2, 3'h3, 3'h6, 3'h7, 3'h7};
    fci_host #(.SETUP_CYC(2), .PULSE_CYC(3), .READ_CYC(4)) dut_u (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i), .req_i(req_i), .op_i(op_i),
        .addr_i(addr_i), .data_i(data_i), .byte_mode_i(byte_mode_i), .q_i(q_i), .busy_o(busy_o),
        .done_o(done_o), .rdata_o(rdata_o), .engine_busy_o(engine_busy_o), .addr_o(addr_o),
        .q_o(q_o), .q_oe_o(q_oe_o), .cs_n_o(cs_n_o), .og_n_o(og_n_o), .vpp_en_o(vpp_en_o),
        .byte_n_o(byte_n_o), .id_hv_en_o(id_hv_en_o)
    );
    fci_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) flash_u (
        .addr_i(addr_o), .q_host_i(q_o), .q_oe_i(q_oe_o), .cs_n_i(cs_n_o), .og_n_i(og_n_o),
        .vpp_i(vpp_en_o), .byte_n_i(byte_n_o), .hv_i(id_hv_en_o), .q_o(q_i),
        .op_cnt_o(op_cnt), .kind_o(kind), .sect_o(sect)
    );
    // ----------------------------------------
    // clock, enable gaps and shared tasks
    // ----------------------------------------
    initial forever #2 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) clk_en_i <= gaps ? (($random(seed) & 3) != 0) : 1'b1;
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one user operation, bounded waits on busy and done
    task automatic run_op(input logic [3:0] op, input logic [19:0] ad, input logic [15:0] dt);
        int n;
        @(posedge core_clk_i);
        req_i <= 1'b1;
        op_i <= op;
        addr_i <= ad;
        data_i <= dt;
        for (n = 0; n < 40 && busy_o !== 1'b1; n++) begin
            @(posedge core_clk_i);
            #1;
        end
        if (n == 40) begin
            miscompares = miscompares + 1;
            finish_test();
        end
        @(posedge core_clk_i);
        req_i <= 1'b0;
        #1;
        for (n = 0; n < 4000 && done_o !== 1'b1; n++) begin
            @(posedge core_clk_i);
            #1;
        end
        if (n == 4000) begin
            miscompares = miscompares + 1;
            finish_test();
        end
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge core_clk_i);
        rst_i <= 1'b0;
        #1;
        check({11'h000, cs_n_o, og_n_o, byte_n_o, busy_o, q_oe_o}, 16'h001c);
        for (i = 0; i < 6; i++) begin
            a = $random(seed);
            e = a[15:0] ^ 16'h5a3c;
            byte_mode_i <= i[0];
            run_op(4'ha, a, 16'h0000);
            check(rdata_o, i[0] ? {8'h00, e[7:0]} : e);
        end
        byte_mode_i <= 1'b0;
        run_op(4'h1, 20'h00000, 16'h0000);
        check(rdata_o, {8'h00, MFR});
        run_op(4'h1, 20'h00001, 16'h0000);
        check(rdata_o, {8'h00, DEV});
        check({8'h00, op_cnt}, 16'h0000);
        cnt = 0;
        for (i = 0; i < 4; i++) begin
            a = {(i == 2) ? 5'h05 : {5{i[0]}}, 15'h0000} | ($random(seed) & 20'h07ffc);
            run_op((i == 3) ? 4'h8 : 4'h7, a, 16'h0000);
            cnt = cnt + ((i == 2) ? 0 : 1);
            check({8'h00, op_cnt}, cnt[15:0]);
            run_op(4'hb, a, 16'h0000);
            check(rdata_o, (i < 2) ? {8'h00, MFR} : 16'h0000);
        end
        gaps <= 1'b1;
        for (i = 0; i < 6; i++) begin
            a = $random(seed);
            e = $random(seed);
            run_op(ops[i], a, e);
            cnt = cnt + 1;
            check({8'h00, op_cnt}, cnt[15:0]);
            check({13'h0000, kind}, {13'h0000, kinds[i]});
            if (i == 0 || i == 2) check({11'h000, sect}, {11'h000, a[19:15]});
            check({15'h0000, engine_busy_o}, {15'h0000, i < 3});
            if (i < 3) begin
                t0 = $time;
                run_op(4'h8, 20'hf8000, 16'h0000);
                check({8'h00, op_cnt}, cnt[15:0]);
                check({15'h0000, ($time - t0) > 100}, 16'h0000);
            end
            for (k = 0; k < 8 && engine_busy_o === 1'b1; k++) run_op(4'h5, 20'h00000, 16'h0000);
            check({15'h0000, engine_busy_o}, 16'h0000);
            if (i == 0) begin
                run_op(4'ha, a, 16'h0000);
                check(rdata_o, 16'h0080);
                run_op(4'h0, a, 16'h0000);
                check(rdata_o, e);
            end
        end
        run_op(4'h0, a, 16'h0000);
        check(rdata_o, a[15:0] ^ 16'h5a3c);
        finish_test();
    end
endmodule
`default_nettype wire
